/* File: rtl/hrbm_defines.svh */
// constants for the host ready and bus master decode block
`ifndef HRBM_DEFINES_SVH
`define HRBM_DEFINES_SVH
`define HRBM_SYNC_STAGES 2
`define HRBM_ACT_N 1'b0
`define HRBM_INACT_N 1'b1
`define HRBM_RST_REFRESH_READY 1'b1
`define HRBM_RST_BURST_READY_OUT_N_OUT 1'b1
`define HRBM_RST_BURST_READY_OUT_N_OE 1'b0
`define HRBM_EISA_IDLE 7'h7F
`endif

/* File: rtl/hrbm_pkg.sv */
// types for the host ready and bus master decode block
package hrbm_pkg;
  typedef struct packed {
    logic [29:0] addr;
    logic [3:0]  byte_en_n;
    logic        mem_io_n;
    logic        data_ctrl_n;
    logic        write_read_n;
  } hrbm_host_cycle_t;
  typedef struct packed {
    logic start_n;
    logic cmd_n;
    logic burst_n;
    logic refresh_n;
    logic read_n;
    logic write_n;
    logic master_n;
  } hrbm_eisa_t;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_DATA_FIRST,
    PH_DATA
  } hrbm_phase_t;
  typedef enum logic [1:0] {
    DRV_OFF,
    DRV_LOW,
    DRV_HIGH
  } hrbm_drive_t;
endpackage

/* File: rtl/hrbm_bridge.sv */
// host ready generation and eisa master command decode
//
// Functional notes
// - host address strobe sampled each clock; active marks new valid cycle
// - burst cpu: burst-last sampled, ignored in address and first data state
// - older cpu: bus controller ready ored with coprocessor ready
// - burst-ready driven low to end a host cycle to local memory
// - after burst-ready low, drive high one clock, then release
// - older cpu: ready low one clock after external ready sampled active
// - refresh-ready high normally, low while hidden refresh pending
// - master burst sampled on bus clock; active means burst transfer
// - with refresh active, read command leading edge requests hidden refresh
// - with master active, asserted read command is a local read
// - with master active, write command leading edge starts local write
// - cycle status sampled with address; write/read with byte enables
`timescale 1ns/1ps
`include "hrbm_defines.svh"
module hrbm_bridge
  import hrbm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             bus_clk,
  input  wire logic             cpu_sel_n,
  input  wire logic             host_addr_strobe_n,
  input  wire logic [29:0]      host_address_bus,
  input  wire logic [3:0]       host_byte_enables_n,
  input  wire logic             host_mem_io_n,
  input  wire logic             host_data_ctrl_n,
  input  wire logic             host_write_read_n,
  input  wire logic             burst_last_or_busctl_ready_n,
  input  wire logic             ready_in_or_copro_ready1_n,
  input  wire logic             copro_ready2_n,
  input  wire logic             host_hold_ack,
  input  wire logic             bus_master_active_n,
  input  wire logic             bus_start_n,
  input  wire logic             bus_cmd_n,
  input  wire logic             master_burst_n,
  input  wire logic             refresh_req_n,
  input  wire logic             mem_read_cmd_n,
  input  wire logic             mem_write_cmd_n,
  input  wire logic             local_mem_done,
  input  wire logic             refresh_done,
  output logic                  burst_ready_out_n_o,
  output logic                  burst_ready_out_n_oe,
  output logic                  refresh_ready_out,
  output hrbm_host_cycle_t      host_cycle,
  output logic                  host_cycle_valid,
  output logic                  burst_capable,
  output logic                  local_read_req,
  output logic                  local_read_active,
  output logic                  local_write_req,
  output logic                  hidden_refresh_req,
  output logic                  eisa_burst_mode,
  output logic                  eisa_access_start,
  output logic                  eisa_cmd_active
);

  // ---- pin synchronisers on the cpu clock
  logic             strap_m;
  logic             strap_s;
  logic             ads_m;
  logic             ads_s;
  logic             last_m;
  logic             last_s;
  logic             rdy1_m;
  logic             rdy1_s;
  logic             rdy2_m;
  logic             rdy2_s;
  logic             hlda_m;
  logic             hlda_s;
  hrbm_host_cycle_t host_m;
  hrbm_host_cycle_t host_s;

  // address and status travel with the strobe so all are aligned
  always_ff @(posedge clk) begin
    if (rst) begin
      ads_m   <= `HRBM_INACT_N;
      ads_s   <= `HRBM_INACT_N;
      last_m  <= `HRBM_INACT_N;
      last_s  <= `HRBM_INACT_N;
      rdy1_m  <= `HRBM_INACT_N;
      rdy1_s  <= `HRBM_INACT_N;
      rdy2_m  <= `HRBM_INACT_N;
      rdy2_s  <= `HRBM_INACT_N;
      hlda_m  <= 1'b0;
      hlda_s  <= 1'b0;
      host_m  <= '0;
      host_s  <= '0;
    end else begin
      ads_m   <= host_addr_strobe_n;
      ads_s   <= ads_m;
      last_m  <= burst_last_or_busctl_ready_n;
      last_s  <= last_m;
      rdy1_m  <= ready_in_or_copro_ready1_n;
      rdy1_s  <= rdy1_m;
      rdy2_m  <= copro_ready2_n;
      rdy2_s  <= rdy2_m;
      hlda_m  <= host_hold_ack;
      hlda_s  <= hlda_m;
      host_m  <= '{addr: host_address_bus, byte_en_n: host_byte_enables_n,
                   mem_io_n: host_mem_io_n, data_ctrl_n: host_data_ctrl_n,
                   write_read_n: host_write_read_n};
      host_s  <= host_m;
    end
  end

  // strap sync has no reset: it must follow the pin while reset is held
  always_ff @(posedge clk) begin
    strap_m <= cpu_sel_n;
    strap_s <= strap_m;
  end

  // strap is caught while reset is held, so it is stable by release
  always_ff @(posedge clk) begin
    if (rst) begin
      burst_capable <= ~strap_s;
    end
  end

  // ---- host cycle phase tracking
  hrbm_phase_t phase;
  hrbm_phase_t next_phase;
  logic        in_data;
  logic        cycle_end;
  logic        any_ready;

  assign in_data   = (phase == PH_DATA_FIRST) || (phase == PH_DATA);
  assign any_ready = local_mem_done || (burst_capable && !rdy1_s);

  // burst-last only counts once past the first data state
  always_comb begin
    if (burst_capable) begin
      cycle_end = (phase == PH_DATA) && any_ready && !last_s;
    end else begin
      cycle_end = in_data && any_ready;
    end
  end

  always_comb begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        if (!ads_s) begin
          next_phase = PH_ADDR;
        end
      end
      PH_ADDR: begin
        next_phase = PH_DATA_FIRST;
      end
      PH_DATA_FIRST: begin
        next_phase = (!burst_capable && any_ready) ? PH_IDLE : PH_DATA;
      end
      PH_DATA: begin
        if (cycle_end) begin
          next_phase = PH_IDLE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // status and byte enables latched on the same strobe sample
  always_ff @(posedge clk) begin
    if (rst) begin
      host_cycle       <= '0;
      host_cycle_valid <= 1'b0;
    end else begin
      host_cycle_valid <= (phase == PH_IDLE) && !ads_s;
      if ((phase == PH_IDLE) && !ads_s) begin
        host_cycle <= host_s;
      end
    end
  end

  // ---- ready output drive
  logic        old_ext_ready;
  logic        assert_now;
  hrbm_drive_t drive;
  hrbm_drive_t next_drive;

  // older cpu: shared pin is the bus controller ready, ored with copro
  assign old_ext_ready = !last_s || !rdy1_s || !rdy2_s;

  always_comb begin
    if (burst_capable) begin
      assert_now = in_data && local_mem_done;
    end else begin
      assert_now = (in_data && local_mem_done) || old_ext_ready;
    end
  end

  // one high clock after the last low keeps the line from floating low
  always_comb begin
    case (drive)
      DRV_OFF:  next_drive = assert_now ? DRV_LOW : DRV_OFF;
      DRV_LOW:  next_drive = assert_now ? DRV_LOW : DRV_HIGH;
      DRV_HIGH: next_drive = assert_now ? DRV_LOW : DRV_OFF;
      default:  next_drive = DRV_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive                <= DRV_OFF;
      burst_ready_out_n_o  <= `HRBM_RST_BURST_READY_OUT_N_OUT;
      burst_ready_out_n_oe <= `HRBM_RST_BURST_READY_OUT_N_OE;
    end else begin
      drive                <= next_drive;
      burst_ready_out_n_o  <= (next_drive == DRV_LOW) ? `HRBM_ACT_N : `HRBM_INACT_N;
      burst_ready_out_n_oe <= (next_drive != DRV_OFF);
    end
  end

  // ---- bus clock side: reset and pin capture
  logic       brst_m;
  logic       brst_s;
  hrbm_eisa_t eisa_pin_m;
  hrbm_eisa_t eisa_bclk;

  always_ff @(posedge bus_clk) begin
    brst_m <= rst;
    brst_s <= brst_m;
  end

  // master burst and commands are sampled on the bus clock rising edge
  always_ff @(posedge bus_clk) begin
    if (brst_s) begin
      eisa_pin_m <= `HRBM_EISA_IDLE;
      eisa_bclk  <= `HRBM_EISA_IDLE;
    end else begin
      eisa_pin_m <= '{start_n: bus_start_n, cmd_n: bus_cmd_n,
                      burst_n: master_burst_n, refresh_n: refresh_req_n,
                      read_n: mem_read_cmd_n, write_n: mem_write_cmd_n,
                      master_n: bus_master_active_n};
      eisa_bclk  <= eisa_pin_m;
    end
  end

  // ---- crossing into the cpu clock
  // each bit is an independent level; commands are wide versus this clock
  hrbm_eisa_t eisa_m;
  hrbm_eisa_t eisa_c;
  hrbm_eisa_t eisa_d;

  always_ff @(posedge clk) begin
    if (rst) begin
      eisa_m <= `HRBM_EISA_IDLE;
      eisa_c <= `HRBM_EISA_IDLE;
      eisa_d <= `HRBM_EISA_IDLE;
    end else begin
      eisa_m <= eisa_bclk;
      eisa_c <= eisa_m;
      eisa_d <= eisa_c;
    end
  end

  logic read_fall;
  logic write_fall;
  logic start_fall;
  logic master_on;
  logic refresh_on;

  // edges only on the settled copies, never the first stage
  assign read_fall  = eisa_d.read_n && !eisa_c.read_n;
  assign write_fall = eisa_d.write_n && !eisa_c.write_n;
  assign start_fall = eisa_d.start_n && !eisa_c.start_n;
  assign master_on  = !eisa_c.master_n && hlda_s;
  assign refresh_on = !eisa_c.refresh_n;

  always_ff @(posedge clk) begin
    if (rst) begin
      eisa_burst_mode   <= 1'b0;
      eisa_access_start <= 1'b0;
      eisa_cmd_active   <= 1'b0;
    end else begin
      eisa_burst_mode   <= !eisa_c.burst_n;
      eisa_access_start <= start_fall;
      eisa_cmd_active   <= !eisa_c.cmd_n;
    end
  end

  // ---- master command decode
  always_ff @(posedge clk) begin
    if (rst) begin
      local_read_req     <= 1'b0;
      local_read_active  <= 1'b0;
      local_write_req    <= 1'b0;
      hidden_refresh_req <= 1'b0;
    end else begin
      hidden_refresh_req <= read_fall && refresh_on;
      local_read_req     <= read_fall && !refresh_on && master_on;
      local_read_active  <= !eisa_c.read_n && !refresh_on && master_on;
      local_write_req    <= write_fall && master_on;
    end
  end

  // ---- hidden refresh pending; a new request wins over a done
  logic refresh_pending;

  always_ff @(posedge clk) begin
    if (rst) begin
      refresh_pending   <= 1'b0;
      refresh_ready_out <= `HRBM_RST_REFRESH_READY;
    end else begin
      if (read_fall && refresh_on) begin
        refresh_pending   <= 1'b1;
        refresh_ready_out <= 1'b0;
      end else if (refresh_done) begin
        refresh_pending   <= 1'b0;
        refresh_ready_out <= 1'b1;
      end
    end
  end

  // ---- checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  strobe_capture_a: assert property ((phase == PH_IDLE && !ads_s) |=>
      (phase == PH_ADDR && host_cycle_valid && host_cycle == $past(host_s)))
    else $error("strobe sample did not start a captured cycle");

  first_states_a: assert property ((phase == PH_ADDR) |=>
      (phase == PH_DATA_FIRST) ##1 (!burst_capable || phase == PH_DATA))
    else $error("burst-last not ignored in first states");

  local_term_a: assert property ((in_data && local_mem_done) |=>
      (burst_ready_out_n_oe && !burst_ready_out_n_o))
    else $error("local cycle end did not drive ready low");

  release_seq_a: assert property ((!burst_ready_out_n_o && !assert_now) |=>
      (burst_ready_out_n_oe && burst_ready_out_n_o) ##1
      (!burst_ready_out_n_oe || !burst_ready_out_n_o))
    else $error("ready not high one clock then released");

  copro_or_a: assert property ((!burst_capable && !rdy2_s) |=>
      !burst_ready_out_n_o)
    else $error("coprocessor ready not merged");

  busctl_ready_a: assert property ((!burst_capable && !last_s) |=>
      (burst_ready_out_n_oe && !burst_ready_out_n_o))
    else $error("bus controller ready not forwarded");

  refresh_pend_a: assert property ((read_fall && refresh_on) |=>
      (!refresh_ready_out && hidden_refresh_req && !local_read_req))
    else $error("hidden refresh not flagged pending");

  refresh_done_a: assert property ((refresh_done && !(read_fall && refresh_on)) |=>
      refresh_ready_out)
    else $error("refresh ready not restored");

  read_decode_a: assert property ((read_fall && !refresh_on && master_on) |=>
      (local_read_req && local_read_active))
    else $error("master read not decoded");

  write_decode_a: assert property ((write_fall && master_on) |=>
      local_write_req ##1 !local_write_req)
    else $error("master write start not a single pulse");

  burst_mode_a: assert property ($fell(eisa_c.burst_n) |=> eisa_burst_mode)
    else $error("burst mode not reported");

endmodule

/* File: verif/hrbm_eisa_model.sv */
// eisa master, refresh and hold model facing the bridge
`timescale 1ns/1ps
module hrbm_eisa_model (
  input  wire logic bus_clk,
  output logic      host_hold_ack,
  output logic      bus_master_active_n,
  output logic      bus_start_n,
  output logic      bus_cmd_n,
  output logic      master_burst_n,
  output logic      refresh_req_n,
  output logic      mem_read_cmd_n,
  output logic      mem_write_cmd_n
);
  // connector lines have pull-ups, so released lines read high
  task automatic idle();
    host_hold_ack = 1'h0;
    {bus_master_active_n, bus_start_n, bus_cmd_n, master_burst_n} = 4'hF;
    {refresh_req_n, mem_read_cmd_n, mem_write_cmd_n} = 3'h7;
  endtask
  initial idle();
  // kind 0 master read, 1 master write, 2 hidden refresh, 3 read with no master
  task automatic access(input int kind, input logic burst, input int len);
    @(negedge bus_clk);
    host_hold_ack = (kind != 2);
    bus_master_active_n = (kind > 1);
    refresh_req_n = (kind != 2);
    master_burst_n = ~burst;
    bus_start_n = 1'h0;
    // start held long enough to cross both synchronizer chains
    repeat (8) @(negedge bus_clk);
    bus_start_n = 1'h1;
    bus_cmd_n = 1'h0;
    mem_read_cmd_n = (kind == 1);
    mem_write_cmd_n = (kind != 1);
    // len sets how slowly the master ends the command
    repeat (len) @(negedge bus_clk);
    idle();
    repeat (12) @(negedge bus_clk);
  endtask
endmodule

/* File: verif/hrbm_bridge_tb.sv */
// self-checking bench for the host ready and bus master decode block
`timescale 1ns/1ps
module hrbm_bridge_tb;
  import hrbm_pkg::*;
  logic             clk = 1'h0;
  logic             rst = 1'h1;
  logic             bus_clk = 1'h0;
  logic             cpu_sel_n = 1'h0;
  logic             host_addr_strobe_n = 1'h1;
  logic [29:0]      host_address_bus = 30'h0;
  logic [3:0]       host_byte_enables_n = 4'hF;
  logic             host_mem_io_n = 1'h1;
  logic             host_data_ctrl_n = 1'h1;
  logic             host_write_read_n = 1'h0;
  logic             burst_last_or_busctl_ready_n = 1'h1;
  logic             ready_in_or_copro_ready1_n = 1'h1;
  logic             copro_ready2_n = 1'h1;
  logic             local_mem_done = 1'h0;
  logic             refresh_done = 1'h0;
  logic             host_hold_ack, bus_master_active_n, bus_start_n, bus_cmd_n;
  logic             master_burst_n, refresh_req_n, mem_read_cmd_n, mem_write_cmd_n;
  logic             burst_ready_out_n_o, burst_ready_out_n_oe, refresh_ready_out, host_cycle_valid;
  logic             burst_capable, local_read_req, local_read_active, local_write_req;
  logic             hidden_refresh_req, eisa_burst_mode, eisa_access_start, eisa_cmd_active;
  hrbm_host_cycle_t host_cycle;
  int               miscompares = 0;
  int               check_count = 0;
  int               cnt [8] = '{default: 0};

  hrbm_bridge dut (
    .clk(clk), .rst(rst), .bus_clk(bus_clk), .cpu_sel_n(cpu_sel_n),
    .host_addr_strobe_n(host_addr_strobe_n), .host_address_bus(host_address_bus),
    .host_byte_enables_n(host_byte_enables_n), .host_mem_io_n(host_mem_io_n),
    .host_data_ctrl_n(host_data_ctrl_n), .host_write_read_n(host_write_read_n),
    .burst_last_or_busctl_ready_n(burst_last_or_busctl_ready_n),
    .ready_in_or_copro_ready1_n(ready_in_or_copro_ready1_n), .copro_ready2_n(copro_ready2_n),
    .host_hold_ack(host_hold_ack), .bus_master_active_n(bus_master_active_n),
    .bus_start_n(bus_start_n), .bus_cmd_n(bus_cmd_n), .master_burst_n(master_burst_n),
    .refresh_req_n(refresh_req_n), .mem_read_cmd_n(mem_read_cmd_n), .mem_write_cmd_n(mem_write_cmd_n),
    .local_mem_done(local_mem_done), .refresh_done(refresh_done),
    .burst_ready_out_n_o(burst_ready_out_n_o), .burst_ready_out_n_oe(burst_ready_out_n_oe),
    .refresh_ready_out(refresh_ready_out), .host_cycle(host_cycle), .host_cycle_valid(host_cycle_valid),
    .burst_capable(burst_capable), .local_read_req(local_read_req), .local_read_active(local_read_active),
    .local_write_req(local_write_req), .hidden_refresh_req(hidden_refresh_req),
    .eisa_burst_mode(eisa_burst_mode), .eisa_access_start(eisa_access_start),
    .eisa_cmd_active(eisa_cmd_active)
  );
  hrbm_eisa_model u_bus (
    .bus_clk(bus_clk), .host_hold_ack(host_hold_ack), .bus_master_active_n(bus_master_active_n),
    .bus_start_n(bus_start_n), .bus_cmd_n(bus_cmd_n), .master_burst_n(master_burst_n),
    .refresh_req_n(refresh_req_n), .mem_read_cmd_n(mem_read_cmd_n), .mem_write_cmd_n(mem_write_cmd_n)
  );

  always #5 clk = ~clk;
  initial begin
    #1.7;
    forever #3 bus_clk = ~bus_clk;
  end

  // running tallies; entry 5 counts refresh requests seen while refresh-ready stayed high
  always @(posedge clk) begin
    if (local_read_req === 1'h1) cnt[0]++;
    if (local_write_req === 1'h1) cnt[1]++;
    if (hidden_refresh_req === 1'h1) cnt[2]++;
    if (eisa_access_start === 1'h1) cnt[3]++;
    if (eisa_burst_mode === 1'h1) cnt[4]++;
    if (hidden_refresh_req === 1'h1 && refresh_ready_out !== 1'h0) cnt[5]++;
    if (local_read_active === 1'h1) cnt[6]++;
    if (eisa_cmd_active === 1'h1) cnt[7]++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(negedge clk);
    rst = 1'h1;
    cpu_sel_n = strap;
    repeat (12) @(negedge clk);
    check(burst_ready_out_n_oe, 1'h0, "ready released in reset");
    check(burst_ready_out_n_o, 1'h1, "ready high in reset");
    check(refresh_ready_out, 1'h1, "refresh ready in reset");
    check(host_cycle_valid, 1'h0, "no cycle in reset");
    check(burst_capable, !strap, "cpu kind from strap");
    rst = 1'h0;
    repeat (3) @(negedge clk);
    $display("reset with strap %0d done", strap);
  endtask

  task automatic test_host_cycle(input logic [29:0] a, input logic [3:0] be, input logic [2:0] st);
    int n;
    host_addr_strobe_n = 1'h0;
    host_address_bus = a;
    host_byte_enables_n = be;
    {host_mem_io_n, host_data_ctrl_n, host_write_read_n} = st;
    @(negedge clk);
    // lines flip at once so a late capture shows up
    host_addr_strobe_n = 1'h1;
    host_address_bus = ~a;
    host_byte_enables_n = ~be;
    {host_mem_io_n, host_data_ctrl_n, host_write_read_n} = ~st;
    for (n = 0; n < 8 && host_cycle_valid !== 1'h1; n++) @(negedge clk);
    check(host_cycle_valid, 1'h1, "strobe taken");
    check(host_cycle, {a, be, st}, "cycle captured");
    @(negedge clk);
    check(host_cycle_valid, 1'h0, "valid one cycle");
    $display("host cycle %h done", a);
  endtask

  task automatic ready_tail();
    @(negedge clk);
    check(burst_ready_out_n_o, 1'h1, "ready high after low");
    check(burst_ready_out_n_oe, 1'h1, "high driven one clock");
    @(negedge clk);
    check(burst_ready_out_n_oe, 1'h0, "ready released");
  endtask

  task automatic done_pulses(input int k);
    int i;
    for (i = 0; i < k; i++) begin
      local_mem_done = 1'h1;
      @(negedge clk);
      check(burst_ready_out_n_o, 1'h0, "ready low");
      check(burst_ready_out_n_oe, 1'h1, "ready driven");
    end
    local_mem_done = 1'h0;
    ready_tail();
  endtask

  task automatic test_burst_cycle();
    int i;
    test_host_cycle(30'h2AAAAAA5, 4'h3, 3'h5);
    repeat (2) @(negedge clk);
    done_pulses(1);
    done_pulses(2);
    // cpu ready with burst-last low ends the cycle but is not echoed
    burst_last_or_busctl_ready_n = 1'h0;
    ready_in_or_copro_ready1_n = 1'h0;
    for (i = 0; i < 6; i++) begin
      @(negedge clk);
      check(burst_ready_out_n_oe, 1'h0, "cpu ready not echoed");
    end
    {burst_last_or_busctl_ready_n, ready_in_or_copro_ready1_n} = 2'h3;
    repeat (2) @(negedge clk);
    test_host_cycle(30'h15555A5A, 4'hC, 3'h2);
    $display("burst cycle test done");
  endtask

  task automatic ext_ready(input int src);
    int n;
    case (src)
      0: burst_last_or_busctl_ready_n = 1'h0;
      1: ready_in_or_copro_ready1_n = 1'h0;
      default: copro_ready2_n = 1'h0;
    endcase
    @(negedge clk);
    {burst_last_or_busctl_ready_n, ready_in_or_copro_ready1_n, copro_ready2_n} = 3'h7;
    for (n = 0; n < 8 && burst_ready_out_n_o !== 1'h0; n++) @(negedge clk);
    check(burst_ready_out_n_oe, 1'h1, "external ready driven");
    check(burst_ready_out_n_o, 1'h0, "external ready low");
    ready_tail();
    $display("older cpu ready source %0d done", src);
  endtask

  task automatic test_eisa(input int kind, input logic burst, input int len);
    int base [8];
    // tallies are owned by the counting process; each test looks at its own increase
    base = cnt;
    u_bus.access(kind, burst, len);
    check(cnt[3] > base[3], 1'h1, "access start seen");
    check(cnt[4] > base[4], burst, "burst mode");
    check(cnt[0] - base[0], kind == 0, "master read");
    check(cnt[6] > base[6], kind == 0, "master read level");
    check(cnt[1] - base[1], kind == 1, "write on leading edge");
    check(cnt[2] - base[2], kind == 2, "hidden refresh request");
    check(cnt[5] - base[5], 0, "refresh ready low with request");
    check(cnt[7] > base[7], 1'h1, "command level seen");
    if (kind == 2) begin
      @(negedge clk);
      check(refresh_ready_out, 1'h0, "refresh pending");
      refresh_done = 1'h1;
      @(negedge clk);
      refresh_done = 1'h0;
      @(negedge clk);
      check(refresh_ready_out, 1'h1, "refresh over");
    end
    $display("bus access kind %0d done", kind);
  endtask

  initial begin
    do_reset(1'h0);
    test_burst_cycle();
    test_eisa(0, 1'h0, 8);
    test_eisa(1, 1'h1, 20);
    test_eisa(2, 1'h0, 8);
    test_eisa(3, 1'h0, 8);
    do_reset(1'h1);
    for (int s = 0; s < 3; s++) ext_ready(s);
    stop_test();
  end

  // the whole sequence needs under two microseconds
  initial begin
    #100us;
    miscompares++;
    stop_test();
  end
endmodule
